// ===== design/motor_fault_map.svh
// Offsets, field positions and reset values of the motor fault protection registers.
// Assumes the registers sit in the motor register space reached through the MCU port.
`ifndef MOTOR_FAULT_MAP_SVH
`define MOTOR_FAULT_MAP_SVH

`define MSFR_AW                7
`define OFS_HALL_STATE_STATUS  7'h1a
`define OFS_OVERCURRENT_CTRL   7'h26
`define OFS_OVERCURRENT_STATUS 7'h27
`define OFS_HIGH_CURRENT_LIMIT 7'h44
`define OFS_LOW_CURRENT_LIMIT  7'h45
`define OFS_SHORT_CIRC_LIMIT   7'h46

`define CTL_OC_EN_BIT          0
`define CTL_SHORT_EN_BIT       1
`define CTL_HALL_EN_BIT        2
`define CTL_RESET              8'h07
`define HIGH_LIMIT_RESET       8'hff
`define LOW_LIMIT_RESET        8'h00
`define SHORT_LIMIT_RESET      8'hff

`define HALL_CODE_ALL_ZERO     3'h0
`define HALL_CODE_ALL_ONE      3'h7

`endif

// ===== design/motor_fault_pkg.sv
// Types shared by the motor fault protection block.
// Assumes motor_fault_map.svh supplies the numeric constants.
package motor_fault_pkg;

    typedef enum logic [1:0]
    {
        GATE_RUN     = 2'b00,
        GATE_OC_OFF  = 2'b01,
        GATE_HALL_OFF = 2'b10
    } gate_e;

endpackage

// ===== design/hall_sync.sv
// Two-flop synchroniser for the asynchronous Hall sensor pins.
// Assumes the pins are unrelated to clk.
`timescale 1ns/1ps

module hall_sync #(
    parameter int WIDTH = 3
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] sync_out
);

    genvar g;
    generate
        for (g = 0; g < WIDTH; g++)
        begin : g_bit
            logic meta_ff;
            logic stab_ff;
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    meta_ff <= 1'b0;
                    stab_ff <= 1'b0;
                end
                else
                begin
                    meta_ff <= pin_in[g];
                    stab_ff <= meta_ff;
                end
            end
            assign sync_out[g] = stab_ff;
        end
    endgenerate

endmodule

// ===== design/motor_fault_protection.sv
// Fault and protection logic: phase-current limits, Hall code check, PWM gating.
// Assumes current results and PWM cycle start come from logic on clk; Hall pins are async.
// Behaviour
// R01: Hall fault holds PWM off until released.
// R02: Over-current checked each cycle, off till next.
// R03: Hall code 111 or 000 is fault.
// R04: Three programmable limits: high, low, short.
// R05: High/low limit breach gates PWM, no interrupt.
// R06: Short-circuit limit breach raises fault interrupt.
// R07: Other protections signal MCU by interrupt.
// R08: Hall period overflow raises interrupt, no gating.
`timescale 1ns/1ps
`include "motor_fault_map.svh"

module motor_fault_protection #(
    parameter int IW = 10
) (
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic [`MSFR_AW-1:0]   msfr_addr,
    input  wire logic                  msfr_wr,
    input  wire logic                  msfr_rd,
    input  wire logic [7:0]            msfr_wdata,
    output logic      [7:0]            msfr_rdata,
    input  wire logic [IW-1:0]         phase_a_current,
    input  wire logic [IW-1:0]         phase_b_current,
    input  wire logic [IW-1:0]         phase_c_current,
    input  wire logic [2:0]            hall_pins,
    input  wire logic                  hall_period_overflow,
    input  wire logic                  pwm_cycle_start,
    input  wire logic [5:0]            pwm_in,
    output logic      [5:0]            pwm_out,
    output logic                       fault_interrupt
);

    logic [2:0]                  hall_code;
    logic [7:0]                  ctl_ff;
    logic [7:0]                  nxt_ctl;
    logic [7:0]                  high_lim_ff;
    logic [7:0]                  nxt_high_lim;
    logic [7:0]                  low_lim_ff;
    logic [7:0]                  nxt_low_lim;
    logic [7:0]                  short_lim_ff;
    logic [7:0]                  nxt_short_lim;
    logic [4:0]                  oc_sta_ff;
    logic [4:0]                  nxt_oc_sta;
    logic                        slow_sta_ff;
    logic                        nxt_slow_sta;
    logic [7:0]                  rdata_ff;
    logic [7:0]                  nxt_rdata;
    logic [5:0]                  pwm_ff;
    logic [5:0]                  nxt_pwm;
    logic                        irq_ff;
    logic                        nxt_irq;
    logic                        prev_hall_flt_ff;
    logic [2:0]                  prev_short_ff;
    motor_fault_pkg::gate_e      gate_ff;
    motor_fault_pkg::gate_e      nxt_gate;

    logic [7:0]                  cur_a;
    logic [7:0]                  cur_b;
    logic [7:0]                  cur_c;
    logic                        oc_high;
    logic                        oc_low;
    logic [2:0]                  short_hit;
    logic                        hall_flt;

    hall_sync #(
        .WIDTH (3)
    ) u_hall_sync (
        .clk      (clk),
        .rst_n    (rst_n),
        .pin_in   (hall_pins),
        .sync_out (hall_code)
    );

    // Only the upper eight result bits meet the 8-bit limits.
    assign cur_a = phase_a_current[IW-1 -: 8];
    assign cur_b = phase_b_current[IW-1 -: 8];
    assign cur_c = phase_c_current[IW-1 -: 8];

    always_comb
    begin
        oc_high   = ctl_ff[`CTL_OC_EN_BIT] && ((cur_a > high_lim_ff) || (cur_b > high_lim_ff)
                    || (cur_c > high_lim_ff)); // see R04, see R05
        oc_low    = ctl_ff[`CTL_OC_EN_BIT] && ((cur_a < low_lim_ff) || (cur_b < low_lim_ff)
                    || (cur_c < low_lim_ff)); // see R04, see R05
        short_hit = ctl_ff[`CTL_SHORT_EN_BIT] ? {cur_c > short_lim_ff, cur_b > short_lim_ff,
                    cur_a > short_lim_ff} : 3'h0; // see R04, see R06
        hall_flt  = ctl_ff[`CTL_HALL_EN_BIT] && ((hall_code == `HALL_CODE_ALL_ZERO)
                    || (hall_code == `HALL_CODE_ALL_ONE)); // see R03
    end

    // Register file, status capture and read data.
    always_comb
    begin
        nxt_ctl       = ctl_ff;
        nxt_high_lim  = high_lim_ff;
        nxt_low_lim   = low_lim_ff;
        nxt_short_lim = short_lim_ff;
        nxt_oc_sta    = oc_sta_ff;
        nxt_slow_sta  = slow_sta_ff;
        nxt_rdata     = rdata_ff;
        if (msfr_wr)
        begin
            if (msfr_addr == `OFS_OVERCURRENT_CTRL)
                nxt_ctl = msfr_wdata;
            else if (msfr_addr == `OFS_HIGH_CURRENT_LIMIT)
                nxt_high_lim = msfr_wdata;
            else if (msfr_addr == `OFS_LOW_CURRENT_LIMIT)
                nxt_low_lim = msfr_wdata;
            else if (msfr_addr == `OFS_SHORT_CIRC_LIMIT)
                nxt_short_lim = msfr_wdata;
        end
        if (msfr_rd)
        begin
            if (msfr_addr == `OFS_HALL_STATE_STATUS)
                nxt_rdata = {3'h0, slow_sta_ff, hall_flt, hall_code};
            else if (msfr_addr == `OFS_OVERCURRENT_CTRL)
                nxt_rdata = ctl_ff;
            else if (msfr_addr == `OFS_OVERCURRENT_STATUS)
                nxt_rdata = {3'h0, oc_sta_ff};
            else if (msfr_addr == `OFS_HIGH_CURRENT_LIMIT)
                nxt_rdata = high_lim_ff;
            else if (msfr_addr == `OFS_LOW_CURRENT_LIMIT)
                nxt_rdata = low_lim_ff;
            else if (msfr_addr == `OFS_SHORT_CIRC_LIMIT)
                nxt_rdata = short_lim_ff;
            else
                nxt_rdata = 8'h00;
            // Sticky bits clear on read; a new event in the same cycle sets them again.
            if (msfr_addr == `OFS_OVERCURRENT_STATUS)
                nxt_oc_sta = 5'h00;
            if (msfr_addr == `OFS_HALL_STATE_STATUS)
                nxt_slow_sta = 1'b0;
        end
        nxt_oc_sta   = nxt_oc_sta | {short_hit, oc_low, oc_high};
        nxt_slow_sta = nxt_slow_sta | hall_period_overflow;
    end

    // PWM gating: Hall fault outranks the cycle-by-cycle trip.
    always_comb
    begin
        nxt_gate = gate_ff;
        case (gate_ff)
            motor_fault_pkg::GATE_RUN:
            begin
                if (hall_flt)
                    nxt_gate = motor_fault_pkg::GATE_HALL_OFF; // see R01
                else if (oc_high || oc_low)
                    nxt_gate = motor_fault_pkg::GATE_OC_OFF; // see R02, see R05
            end
            motor_fault_pkg::GATE_OC_OFF:
            begin
                if (hall_flt)
                    nxt_gate = motor_fault_pkg::GATE_HALL_OFF; // see R01
                else if (pwm_cycle_start)
                    nxt_gate = motor_fault_pkg::GATE_RUN; // see R02
            end
            motor_fault_pkg::GATE_HALL_OFF:
            begin
                if (!hall_flt)
                    nxt_gate = motor_fault_pkg::GATE_RUN; // see R01
            end
            default:
                nxt_gate = motor_fault_pkg::GATE_HALL_OFF;
        endcase
        // A trip seen on the cycle start itself is kept, so the new cycle starts off.
        if (pwm_cycle_start && (oc_high || oc_low) && !hall_flt)
            nxt_gate = motor_fault_pkg::GATE_OC_OFF; // see R02
        // The condition gates in the same cycle it is seen, not one later.
        if (hall_flt || oc_high || oc_low || (nxt_gate != motor_fault_pkg::GATE_RUN))
            nxt_pwm = 6'h00; // see R01, see R03, see R05
        else
            nxt_pwm = pwm_in;
        // Interrupt pulses on the rise of a Hall or short fault and follows hall_period_overflow, never for high/low trips.
        nxt_irq = (hall_flt && !prev_hall_flt_ff) // see R03, see R07
                  || |(short_hit & ~prev_short_ff) // see R06, see R07
                  || hall_period_overflow; // see R08
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctl_ff           <= `CTL_RESET;
            high_lim_ff      <= `HIGH_LIMIT_RESET;
            low_lim_ff       <= `LOW_LIMIT_RESET;
            short_lim_ff     <= `SHORT_LIMIT_RESET;
            oc_sta_ff        <= 5'h00;
            slow_sta_ff      <= 1'b0;
            rdata_ff         <= 8'h00;
            gate_ff          <= motor_fault_pkg::GATE_RUN;
            pwm_ff           <= 6'h00;
            irq_ff           <= 1'b0;
            prev_hall_flt_ff <= 1'b0;
            prev_short_ff    <= 3'h0;
        end
        else
        begin
            ctl_ff           <= nxt_ctl;
            high_lim_ff      <= nxt_high_lim;
            low_lim_ff       <= nxt_low_lim;
            short_lim_ff     <= nxt_short_lim;
            oc_sta_ff        <= nxt_oc_sta;
            slow_sta_ff      <= nxt_slow_sta;
            rdata_ff         <= nxt_rdata;
            gate_ff          <= nxt_gate;
            pwm_ff           <= nxt_pwm;
            irq_ff           <= nxt_irq;
            prev_hall_flt_ff <= hall_flt;
            prev_short_ff    <= short_hit;
        end
    end

    assign msfr_rdata      = rdata_ff;
    assign pwm_out         = pwm_ff;
    assign fault_interrupt = irq_ff;

endmodule

// ===== testbench/mfp_asserts.sv
// Checker for the motor fault protection ports.
// Assumes the current limits and check enables change only through msfr writes.
`timescale 1ns/1ps
`include "motor_fault_map.svh"
module mfp_asserts #(
    parameter int IW = 10
) (
    input wire logic                clk,
    input wire logic                rst_n,
    input wire logic [`MSFR_AW-1:0] msfr_addr,
    input wire logic                msfr_wr,
    input wire logic                msfr_rd,
    input wire logic [7:0]          msfr_wdata,
    input wire logic [7:0]          msfr_rdata,
    input wire logic [IW-1:0]       phase_a_current,
    input wire logic [IW-1:0]       phase_b_current,
    input wire logic [IW-1:0]       phase_c_current,
    input wire logic [2:0]          hall_pins,
    input wire logic                hall_period_overflow,
    input wire logic                pwm_cycle_start,
    input wire logic [5:0]          pwm_in,
    input wire logic [5:0]          pwm_out,
    input wire logic                fault_interrupt
);
    logic [7:0] hi_ff, lo_ff, sh_ff, en_ff, ca, cb, cc;
    logic       trip, shrt, hall_ok;
    assign ca = phase_a_current[IW-1 -: 8];
    assign cb = phase_b_current[IW-1 -: 8];
    assign cc = phase_c_current[IW-1 -: 8];
    // A disabled check must not count as a trip, or the gating checks would misfire.
    assign trip = en_ff[`CTL_OC_EN_BIT] && (ca > hi_ff || cb > hi_ff || cc > hi_ff
               || ca < lo_ff || cb < lo_ff || cc < lo_ff);
    assign shrt = en_ff[`CTL_SHORT_EN_BIT] && (ca > sh_ff || cb > sh_ff || cc > sh_ff);
    assign hall_ok = !en_ff[`CTL_HALL_EN_BIT]
                  || (hall_pins != `HALL_CODE_ALL_ZERO && hall_pins != `HALL_CODE_ALL_ONE);
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hi_ff <= `HIGH_LIMIT_RESET;
            lo_ff <= `LOW_LIMIT_RESET;
            sh_ff <= `SHORT_LIMIT_RESET;
            en_ff <= `CTL_RESET;
        end
        else if (msfr_wr)
        begin
            if (msfr_addr == `OFS_HIGH_CURRENT_LIMIT) hi_ff <= msfr_wdata;
            if (msfr_addr == `OFS_LOW_CURRENT_LIMIT) lo_ff <= msfr_wdata;
            if (msfr_addr == `OFS_SHORT_CIRC_LIMIT) sh_ff <= msfr_wdata;
            if (msfr_addr == `OFS_OVERCURRENT_CTRL) en_ff <= msfr_wdata;
        end
    end
    default clocking dflt @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    a_hall_gate_off: assert property ((!hall_ok)[*5] |-> pwm_out == 6'h00)
        else $error("pwm on during hall fault");
    a_oc_gate_off: assert property (trip |=> pwm_out == 6'h00)
        else $error("pwm on after current trip");
    a_oc_hold_off: assert property (
        trip ##1 !(trip || pwm_cycle_start) |=> pwm_out == 6'h00)
        else $error("pwm back on before cycle start");
    a_cycle_release: assert property (
        (hall_ok && !trip)[*6] ##0 pwm_cycle_start |=> pwm_out == $past(pwm_in))
        else $error("pwm not restored at cycle start");
    a_quiet_limits: assert property (
        (hall_ok && !shrt && !hall_period_overflow)[*6] |-> !fault_interrupt)
        else $error("interrupt without a cause");
    a_short_irq: assert property ($rose(shrt) |=> fault_interrupt)
        else $error("no interrupt on short");
    a_slow_irq: assert property (hall_period_overflow |=> fault_interrupt)
        else $error("no interrupt on hall overflow");
    a_hall_irq: assert property (
        hall_ok ##1 (!hall_ok)[*3] |-> ##[0:2] fault_interrupt)
        else $error("no interrupt on hall fault");
endmodule
bind motor_fault_protection mfp_asserts #(.IW(IW)) u_chk (.*);

// ===== testbench/power_stage_model.sv
// Behavioural power stage: phase currents, Hall sensors and PWM cycle start.
// Assumes the bench steers it through its tasks; outputs move on the falling edge.
`timescale 1ns/1ps
module power_stage_model #(
    parameter int IW    = 10,
    parameter int CYCLE = 16
) (
    input  wire logic clk,
    output logic [IW-1:0] phase_a_current,
    output logic [IW-1:0] phase_b_current,
    output logic [IW-1:0] phase_c_current,
    output logic [2:0]    hall_pins,
    output logic          hall_period_overflow,
    output logic          pwm_cycle_start
);
    logic [2:0] rot [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
    logic [2:0] bad_code = 3'h0;
    logic       bad_en = 1'h0;
    logic       slow = 1'h0;
    int         tick = 0;
    initial
    begin
        {phase_a_current, phase_b_current, phase_c_current} = {3{10'h200}};
        {hall_pins, hall_period_overflow, pwm_cycle_start} = 5'h04;
    end
    // Valid codes rotate so the block sees a turning motor, never 000 or 111.
    always @(negedge clk)
    begin
        tick++;
        pwm_cycle_start <= (tick % CYCLE) == 0;
        hall_pins <= bad_en ? bad_code : rot[(tick / 8) % 6];
        hall_period_overflow <= slow;
        slow = 1'h0;
    end
    task automatic set_cur(input logic [IW-1:0] a, input logic [IW-1:0] b,
                           input logic [IW-1:0] c);
        {phase_a_current, phase_b_current, phase_c_current} = {a, b, c};
    endtask
    task automatic hall(input logic en, input logic [2:0] code);
        {bad_en, bad_code} = {en, code};
    endtask
    task automatic pulse_slow;
        slow = 1'h1;
    endtask
endmodule

// ===== testbench/tb.sv
// Self-checking bench for motor_fault_protection driven by a power stage model.
// Assumes the design header is on the include path.
`timescale 1ns/1ps
`include "motor_fault_map.svh"
module tb;
    localparam int IW = 10;
    logic          clk = 1'h0, rst_n = 1'h0, msfr_wr = 1'h0, msfr_rd = 1'h0, fault_interrupt;
    logic [6:0]    msfr_addr = 7'h00;
    logic [7:0]    msfr_wdata = 8'h00, msfr_rdata, v;
    logic [IW-1:0] phase_a_current, phase_b_current, phase_c_current;
    logic [2:0]    hall_pins;
    logic          hall_period_overflow, pwm_cycle_start;
    logic [5:0]    pwm_in = 6'h00, pwm_out;
    int            err_total = 0, total_checks = 0, irqs = 0, n;
    always #2 clk = ~clk;
    always @(negedge clk) pwm_in <= pwm_in + 6'h01;
    always @(posedge fault_interrupt) irqs++;
    power_stage_model #(.IW(IW)) u_stage (.*);
    motor_fault_protection #(.IW(IW)) u_dut (.*);
    task automatic final_report;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(negedge clk);
        {msfr_addr, msfr_wdata, msfr_wr} = {a, d, 1'h1};
        @(negedge clk);
        msfr_wr = 1'h0;
    endtask
    task automatic rdc(input logic [6:0] a, input logic [7:0] e);
        @(negedge clk);
        {msfr_addr, msfr_rd} = {a, 1'h1};
        @(negedge clk);
        msfr_rd = 1'h0;
        chk("msfr_rdata", msfr_rdata, e);
    endtask
    task automatic wait_start;
        for (n = 0; n < 40 && pwm_cycle_start !== 1'h1; n++) @(posedge clk);
        @(negedge clk);
        // A missing cycle start is a failure, never a silent end of the run.
        if (n == 40)
        begin
            chk("pwm_cycle_start", 8'h00, 8'h01);
            final_report();
        end
    endtask
    task automatic irq_within(input int lim);
        for (n = 0; n < lim && fault_interrupt !== 1'h1; n++) @(negedge clk);
        chk("fault_interrupt", fault_interrupt, 8'h01);
        if (n == lim) final_report();
    endtask
    task automatic t_regs;
        rdc(`OFS_OVERCURRENT_CTRL, `CTL_RESET);
        rdc(`OFS_HIGH_CURRENT_LIMIT, 8'hff);
        rdc(`OFS_LOW_CURRENT_LIMIT, 8'h00);
        rdc(`OFS_SHORT_CIRC_LIMIT, 8'hff);
        wr(`OFS_HIGH_CURRENT_LIMIT, 8'hc0);
        wr(`OFS_LOW_CURRENT_LIMIT, 8'h20);
        wr(`OFS_SHORT_CIRC_LIMIT, 8'he0);
        wr(`OFS_OVERCURRENT_STATUS, 8'hff);
        rdc(`OFS_HIGH_CURRENT_LIMIT, 8'hc0);
        rdc(`OFS_LOW_CURRENT_LIMIT, 8'h20);
        rdc(`OFS_SHORT_CIRC_LIMIT, 8'he0);
        rdc(`OFS_OVERCURRENT_STATUS, 8'h00);
        rdc(7'h10, 8'h00);
    endtask
    task automatic t_oc(input logic [IW-1:0] a, input logic [IW-1:0] b, input logic [7:0] st);
        v = irqs[7:0];
        wait_start();
        u_stage.set_cur(a, b, 10'h200);
        repeat (2) @(negedge clk);
        chk("pwm_out", pwm_out, 8'h00);
        u_stage.set_cur(10'h200, 10'h200, 10'h200);
        repeat (3) @(negedge clk);
        chk("pwm_out", pwm_out, 8'h00);
        wait_start();
        chk("pwm_out", pwm_out, pwm_in);
        chk("irqs", irqs[7:0], v);
        rdc(`OFS_OVERCURRENT_STATUS, st);
    endtask
    task automatic t_short;
        wait_start();
        u_stage.set_cur(10'h200, 10'h200, 10'h3c0);
        irq_within(3);
        // Current drops before the read so the sticky bits really clear.
        u_stage.set_cur(10'h200, 10'h200, 10'h200);
        rdc(`OFS_OVERCURRENT_STATUS, 8'h11);
    endtask
    task automatic t_ctl;
        wr(`OFS_OVERCURRENT_CTRL, 8'h06);
        rdc(`OFS_OVERCURRENT_CTRL, 8'h06);
        wait_start();
        u_stage.set_cur(10'h340, 10'h040, 10'h200);
        repeat (2) @(negedge clk);
        chk("pwm_out", pwm_out, pwm_in);
        u_stage.set_cur(10'h200, 10'h200, 10'h200);
        rdc(`OFS_OVERCURRENT_STATUS, 8'h00);
        wr(`OFS_OVERCURRENT_CTRL, `CTL_RESET);
        rdc(`OFS_OVERCURRENT_CTRL, `CTL_RESET);
    endtask
    task automatic t_hall(input logic [2:0] code);
        u_stage.hall(1'h1, code);
        irq_within(6);
        repeat (20) @(negedge clk);
        chk("pwm_out", pwm_out, 8'h00);
        rdc(`OFS_HALL_STATE_STATUS, {5'h01, code});
        u_stage.hall(1'h0, code);
        repeat (8) @(negedge clk);
        chk("pwm_out", pwm_out, pwm_in);
    endtask
    task automatic t_slow;
        u_stage.pulse_slow();
        irq_within(4);
        chk("pwm_out", pwm_out, pwm_in);
    endtask
    initial
    begin
        repeat (6) @(negedge clk);
        rst_n = 1'h1;
        repeat (8) @(negedge clk);
        t_regs();
        t_oc(10'h340, 10'h200, 8'h01);
        t_oc(10'h200, 10'h040, 8'h02);
        t_short();
        t_hall(3'h0);
        t_hall(3'h7);
        t_slow();
        t_ctl();
        final_report();
    end
endmodule
